// ===== logic/periph_clock_gate.sv
// One peripheral clock gate, a flop-built copy of the system clock.
// Assumes clk_now is the registered system clock and clk_next its next value.
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_cfg.svh"

module periph_clock_gate (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_now,
	input wire logic clk_next,
	input wire logic enable,
	output logic gated_clock
);
	logic en_hold_r;
	logic eff;

	// Enable may only change while the clock is low, so no high phase is cut
	assign eff = clk_now ? en_hold_r : enable; // RULE21

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_hold_r <= `CS_RST_PERIPH_EN;
			gated_clock <= 1'b0;
		end else begin
			if (!clk_now) begin
				en_hold_r <= enable;
			end
			gated_clock <= clk_next & eff; // RULE7
		end
	end
endmodule // periph_clock_gate
`default_nettype wire

// ===== logic/pll_synth.sv
// Digital PLL: output = reference * (mult+4) / (div+4).
// Assumes ref_clk is filtered, aclk-sampled and far slower than aclk.
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_cfg.svh"

module pll_synth #(
	parameter int PW = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ref_clk,
	input wire clock_select_pkg::pll_cfg_t cfg,
	output logic pll_clock,
	output logic locked
);
	logic ref_prev_r;
	logic [PW-1:0] cnt_r;
	logic [PW-1:0] period_r;
	logic [29:0] acc_r;
	logic [3:0] lock_cnt_r;
	logic rise, run, near;
	logic [12:0] mult_eff, div_eff;
	logic [29:0] thresh, acc_sum;
	logic [PW-1:0] diff;

	assign rise = ref_clk & ~ref_prev_r;
	assign run = ~cfg.powerdown & ~cfg.standby; // RULE17
	assign mult_eff = {1'b0, cfg.mult} + `CS_RATIO_OFFSET;
	assign div_eff = {1'b0, cfg.div} + `CS_RATIO_OFFSET;
	assign thresh = 30'(period_r) * 30'(div_eff);
	assign acc_sum = acc_r + {16'h0000, mult_eff, 1'b0};
	assign diff = cnt_r - period_r;
	// Sampling leaves one aclk of jitter on the measured period
	assign near = (diff == '0) | (diff == PW'(1)) | (diff == '1);
	assign locked = (lock_cnt_r == `CS_LOCK_REF_PERIODS);

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			ref_prev_r <= 1'b0;
			cnt_r <= '0;
			period_r <= '0;
		end else begin
			ref_prev_r <= ref_clk;
			if (rise) begin
				cnt_r <= PW'(1);
				period_r <= cnt_r;
			end else if (cnt_r != '1) begin
				cnt_r <= cnt_r + PW'(1);
			end
		end
	end

	// One toggle per period*(div+4) gained in steps of 2*(mult+4); restart on each reference edge
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			acc_r <= '0;
			pll_clock <= 1'b0;
		end else if (rise) begin
			acc_r <= '0;
			pll_clock <= 1'b1; // RULE14
		end else if (acc_sum >= thresh) begin
			acc_r <= acc_sum - thresh;
			pll_clock <= ~pll_clock; // RULE4
		end else begin
			acc_r <= acc_sum;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			lock_cnt_r <= '0;
		end else if (rise) begin
			if (!near) begin
				lock_cnt_r <= '0;
			end else if (!locked) begin
				lock_cnt_r <= lock_cnt_r + 4'h1;
			end
		end
	end
endmodule // pll_synth
`default_nettype wire

// ===== logic/system_clock_select.sv
// Clock select: reference, bypass/PLL path, glitch-free switch, domain clocks,
// peripheral gates and AXI4-Lite registers.
// Assumes pins asynchronous to aclk, all clocks far slower than aclk.
//
// Function
// [RULE1] Reference from RTC oscillator or external pin
// [RULE2] USB reference from its own oscillator
// [RULE3] RTC registers inaccessible with external reference
// [RULE4] PLL path multiplies and divides the reference
// [RULE5] Bypass routes reference unchanged to system clock
// [RULE6] CPU domain runs directly on system clock
// [RULE7] Every peripheral has its own clock gate
// [RULE8] Peripheral clocks come straight from system clock
// [RULE9] Powered-down generator forces reference as source
// [RULE10] USB oscillator and PLL can be disabled
// [RULE11] RTC domain always runs, issues wake-ups
// [RULE12] Strap pin picks the reference source
// [RULE13] Path-select bit chooses bypass or PLL
// [RULE14] PLL output phase-aligned to its reference
// [RULE15] No glitch or runt when switching paths
// [RULE16] Status bit tri-states debug clock pin
// [RULE17] Reset: bypass selected, PLL in standby
// [RULE18] Strap low picks RTC, otherwise external pin
// [RULE19] Software checks lock before selecting PLL
// [RULE20] Software returns to bypass before reprogramming
// [RULE21] Peripheral gates switch only while clock low
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_cfg.svh"

module system_clock_select #(
	parameter int PERIPH_COUNT = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`CS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`CS_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rtc_osc_clock,
	input wire logic ext_ref_clock_pin,
	input wire logic ref_source_strap,
	input wire logic usb_osc_clock,
	input wire logic rtc_wake_request,
	output logic core_system_clock,
	output logic cpu_domain_clock,
	output logic [PERIPH_COUNT-1:0] periph_clock,
	output logic pll_reference_input,
	output logic usb_ref_clock,
	output logic usb_osc_enable,
	output logic usb_pll_enable,
	output logic rtc_regs_accessible,
	output logic rtc_wakeup_event,
	output logic debug_clock_output,
	output logic debug_clock_output_oe
);
	localparam int PINS = 5;
	localparam int P_RTC = 0;
	localparam int P_EXT = 1;
	localparam int P_STRAP = 2;
	localparam int P_USB = 3;
	localparam int P_WAKE = 4;

	// Pin synchronisers: a change counts once the last two flops agree
	logic [PINS-1:0] pin_in, s1_r, s2_r, s3_r, filt_r;
	assign pin_in = {rtc_wake_request, usb_osc_clock, ref_source_strap,
		ext_ref_clock_pin, rtc_osc_clock};

	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1_r[gi] <= 1'b0;
					s2_r[gi] <= 1'b0;
					s3_r[gi] <= 1'b0;
					filt_r[gi] <= 1'b0;
				end else begin
					s1_r[gi] <= pin_in[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi]) begin
						filt_r[gi] <= s3_r[gi];
					end
				end
			end
		end
	endgenerate

	logic path_select_r, powerdown_r, standby_r;
	logic [11:0] mult_r, div_r;
	logic [PERIPH_COUNT-1:0] periph_en_r;
	logic usb_osc_en_r, usb_pll_en_r, dbg_disable_r;

	clock_select_pkg::switch_state_t sw_state_r;
	logic pll_active_r, sys_clk_r, sys_clk_nxt;
	logic ref_clk, want_pll, cur_src, pll_clock, pll_locked, wake_prev_r;
	clock_select_pkg::pll_cfg_t pll_cfg;

	// Strap low takes the RTC oscillator, high the external pin
	assign ref_clk = filt_r[P_STRAP] ? filt_r[P_EXT] : filt_r[P_RTC]; // RULE1 RULE12 RULE18

	assign pll_cfg.mult = mult_r;
	assign pll_cfg.div = div_r;
	assign pll_cfg.powerdown = powerdown_r;
	assign pll_cfg.standby = standby_r;

	pll_synth #(.PW(16)) u_pll (
		.aclk(aclk),
		.aresetn(aresetn),
		.ref_clk(ref_clk),
		.cfg(pll_cfg),
		.pll_clock(pll_clock),
		.locked(pll_locked)
	);

	// A stopped PLL can never be the source, whatever the select bit says
	assign want_pll = path_select_r & ~powerdown_r & ~standby_r; // RULE9 RULE13
	assign cur_src = pll_active_r ? pll_clock : ref_clk; // RULE5

	// Old source is held low before the new one is let through on a low phase
	always_comb begin
		case (sw_state_r)
			clock_select_pkg::SW_RUN: sys_clk_nxt = cur_src;
			clock_select_pkg::SW_STOP_OLD: sys_clk_nxt = sys_clk_r & cur_src; // RULE15
			clock_select_pkg::SW_WAIT_NEW: sys_clk_nxt = 1'b0; // RULE15
			clock_select_pkg::SW_RESUME: sys_clk_nxt = cur_src;
			default: sys_clk_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_state_r <= clock_select_pkg::SW_RUN;
			pll_active_r <= 1'b0; // RULE17
		end else begin
			case (sw_state_r)
				clock_select_pkg::SW_RUN: begin
					if (want_pll != pll_active_r) begin
						sw_state_r <= clock_select_pkg::SW_STOP_OLD;
					end
				end
				clock_select_pkg::SW_STOP_OLD: begin
					if (!sys_clk_r) begin
						pll_active_r <= want_pll;
						sw_state_r <= clock_select_pkg::SW_WAIT_NEW;
					end
				end
				clock_select_pkg::SW_WAIT_NEW: begin
					// Starting on a low phase avoids a short first high
					if (!cur_src) begin
						sw_state_r <= clock_select_pkg::SW_RESUME;
					end
				end
				clock_select_pkg::SW_RESUME: sw_state_r <= clock_select_pkg::SW_RUN;
				default: sw_state_r <= clock_select_pkg::SW_RUN;
			endcase
		end
	end

	// Clock outputs, all from flops on the same edge so they stay aligned
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_clk_r <= 1'b0;
			cpu_domain_clock <= 1'b0;
			pll_reference_input <= 1'b0;
			debug_clock_output <= 1'b0;
			debug_clock_output_oe <= 1'b0;
		end else begin
			sys_clk_r <= sys_clk_nxt;
			cpu_domain_clock <= sys_clk_nxt; // RULE6
			pll_reference_input <= ref_clk;
			debug_clock_output <= sys_clk_nxt;
			debug_clock_output_oe <= ~dbg_disable_r; // RULE16
		end
	end
	assign core_system_clock = sys_clk_r;

	// Undivided copies; slower rates are each peripheral's own business
	generate
		for (gi = 0; gi < PERIPH_COUNT; gi++) begin : g_gate
			periph_clock_gate u_gate (
				.aclk(aclk),
				.aresetn(aresetn),
				.clk_now(sys_clk_r),
				.clk_next(sys_clk_nxt),
				.enable(periph_en_r[gi]),
				.gated_clock(periph_clock[gi])
			); // RULE7 RULE8
		end
	endgenerate

	// USB and RTC domains; RTC wake-ups ignore every other gate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			usb_ref_clock <= 1'b0;
			usb_osc_enable <= 1'b0;
			usb_pll_enable <= 1'b0;
			rtc_regs_accessible <= 1'b0;
			wake_prev_r <= 1'b0;
			rtc_wakeup_event <= 1'b0;
		end else begin
			usb_ref_clock <= filt_r[P_USB] & usb_osc_en_r; // RULE2
			usb_osc_enable <= usb_osc_en_r; // RULE10
			usb_pll_enable <= usb_pll_en_r & usb_osc_en_r; // RULE10
			rtc_regs_accessible <= ~filt_r[P_STRAP]; // RULE3
			wake_prev_r <= filt_r[P_WAKE];
			rtc_wakeup_event <= filt_r[P_WAKE] & ~wake_prev_r; // RULE11
		end
	end

	// AXI4-Lite slave: address and data taken in either order, one write queued
	logic aw_held_r, w_held_r;
	logic [`CS_ADDR_W-1:0] aw_addr_r;
	logic [31:0] w_data_r, wr_word;
	logic [3:0] w_strb_r;
	logic do_write;

	assign s_axi_awready = ~aw_held_r;
	assign s_axi_wready = ~w_held_r;
	assign s_axi_arready = ~s_axi_rvalid;
	assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;

	function automatic logic is_mapped(input logic [`CS_ADDR_W-1:0] a);
		return {a[`CS_ADDR_W-1:2], 2'b00} <= `CS_OFF_CLOCK_STATUS;
	endfunction

	function automatic logic [31:0] read_word(input logic [`CS_ADDR_W-1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case ({a[`CS_ADDR_W-1:2], 2'b00})
			`CS_OFF_CLOCK_CONFIG_TWO: v[`CS_BIT_PATH_SELECT] = path_select_r;
			`CS_OFF_GEN_CONTROL_ONE: begin
				v[`CS_BIT_POWERDOWN] = powerdown_r;
				v[`CS_BIT_STANDBY] = standby_r;
			end
			`CS_OFF_PLL_RATIO: begin
				v[`CS_POS_MULT +: 12] = mult_r;
				v[`CS_POS_DIV +: 12] = div_r;
			end
			`CS_OFF_GEN_CONTROL_THREE: v[`CS_BIT_LOCK] = pll_locked;
			`CS_OFF_PERIPH_GATE: v[PERIPH_COUNT-1:0] = periph_en_r;
			`CS_OFF_USB_CONTROL: begin
				v[`CS_BIT_USB_OSC] = usb_osc_en_r;
				v[`CS_BIT_USB_PLL] = usb_pll_en_r;
			end
			`CS_OFF_CPU_STATUS_THREE: v[`CS_BIT_DBG_DISABLE] = dbg_disable_r;
			`CS_OFF_CLOCK_STATUS: v[3:0] = {sw_state_r != clock_select_pkg::SW_RUN,
				~filt_r[P_STRAP], pll_active_r, filt_r[P_STRAP]};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// Byte lanes merge into the current value; read-only words ignore writes
	always_comb begin
		wr_word = read_word(aw_addr_r);
		for (int b = 0; b < 4; b++) begin
			if (w_strb_r[b]) begin
				wr_word[8*b +: 8] = w_data_r[8*b +: 8];
			end
		end
	end
	function automatic logic wr_at(input logic [`CS_ADDR_W-1:0] off);
		return do_write && ({aw_addr_r[`CS_ADDR_W-1:2], 2'b00} == off);
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_r <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_addr_r) ? `CS_RESP_OKAY : `CS_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `CS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word(s_axi_araddr);
			s_axi_rresp <= is_mapped(s_axi_araddr) ? `CS_RESP_OKAY : `CS_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Generator controls; lock is not enforced here, software checks it first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			path_select_r <= `CS_RST_PATH_SELECT; // RULE17
			powerdown_r <= `CS_RST_POWERDOWN;
			standby_r <= `CS_RST_STANDBY; // RULE17
			mult_r <= `CS_RST_RATIO;
			div_r <= `CS_RST_RATIO;
		end else begin
			if (wr_at(`CS_OFF_CLOCK_CONFIG_TWO)) begin
				path_select_r <= wr_word[`CS_BIT_PATH_SELECT]; // RULE13 RULE19
			end
			if (wr_at(`CS_OFF_GEN_CONTROL_ONE)) begin
				powerdown_r <= wr_word[`CS_BIT_POWERDOWN];
				standby_r <= wr_word[`CS_BIT_STANDBY];
			end
			if (wr_at(`CS_OFF_PLL_RATIO)) begin
				mult_r <= wr_word[`CS_POS_MULT +: 12]; // RULE20
				div_r <= wr_word[`CS_POS_DIV +: 12];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_en_r <= {PERIPH_COUNT{`CS_RST_PERIPH_EN}};
			usb_osc_en_r <= `CS_RST_USB;
			usb_pll_en_r <= `CS_RST_USB;
			dbg_disable_r <= `CS_RST_DBG_DISABLE;
		end else begin
			if (wr_at(`CS_OFF_PERIPH_GATE)) begin
				periph_en_r <= wr_word[PERIPH_COUNT-1:0]; // RULE7
			end
			if (wr_at(`CS_OFF_USB_CONTROL)) begin
				usb_osc_en_r <= wr_word[`CS_BIT_USB_OSC];
				usb_pll_en_r <= wr_word[`CS_BIT_USB_PLL];
			end
			if (wr_at(`CS_OFF_CPU_STATUS_THREE)) begin
				dbg_disable_r <= wr_word[`CS_BIT_DBG_DISABLE]; // RULE16
			end
		end
	end
endmodule // system_clock_select
`default_nettype wire

// ===== pkg/clock_select_cfg.svh
// Register offsets, field positions, reset values and counts of the clock select block.
// Assumes a 32-bit AXI4-Lite register window with 8-bit byte addresses.
`ifndef CLOCK_SELECT_CFG_SVH
`define CLOCK_SELECT_CFG_SVH

`define CS_ADDR_W 8
`define CS_OFF_CLOCK_CONFIG_TWO 8'h00
`define CS_OFF_GEN_CONTROL_ONE 8'h04
`define CS_OFF_PLL_RATIO 8'h08
`define CS_OFF_GEN_CONTROL_THREE 8'h0C
`define CS_OFF_PERIPH_GATE 8'h10
`define CS_OFF_USB_CONTROL 8'h14
`define CS_OFF_CPU_STATUS_THREE 8'h18
`define CS_OFF_CLOCK_STATUS 8'h1C

`define CS_BIT_PATH_SELECT 0
`define CS_BIT_POWERDOWN 0
`define CS_BIT_STANDBY 1
`define CS_BIT_LOCK 3
`define CS_BIT_USB_OSC 0
`define CS_BIT_USB_PLL 1
`define CS_BIT_DBG_DISABLE 0
`define CS_POS_MULT 0
`define CS_POS_DIV 16

`define CS_RST_PATH_SELECT 1'b0
`define CS_RST_POWERDOWN 1'b0
`define CS_RST_STANDBY 1'b1
`define CS_RST_RATIO 12'h000
`define CS_RST_PERIPH_EN 1'b1
`define CS_RST_USB 1'b0
`define CS_RST_DBG_DISABLE 1'b1

`define CS_RATIO_OFFSET 13'h0004
`define CS_LOCK_REF_PERIODS 4'h8
`define CS_RESP_OKAY 2'b00
`define CS_RESP_SLVERR 2'b10

`endif

// ===== pkg/clock_select_pkg.sv
// Types shared by the clock select block and its phase-locked synthesiser.
// Assumes nothing of its surroundings.
package clock_select_pkg;

	typedef enum logic [1:0] {
		SW_RUN = 2'b00,
		SW_STOP_OLD = 2'b01,
		SW_WAIT_NEW = 2'b11,
		SW_RESUME = 2'b10
	} switch_state_t;

	typedef struct packed {
		logic [11:0] mult;
		logic [11:0] div;
		logic powerdown;
		logic standby;
	} pll_cfg_t;

endpackage

// ===== tb/clock_consumer_model.sv
// Far side: oscillators and consumers counting clock edges.
// Assumes clocks far slower than aclk; clear restarts counts.
`timescale 1ns/1ps
`default_nettype none

module clock_consumer_model #(
	parameter int RTC_HALF = 20,
	parameter int EXT_HALF = 12,
	parameter int USB_HALF = 4,
	parameter int PN = 8
) (
	input wire logic aclk,
	input wire logic clear,
	input wire logic [PN+3:0] taps,
	output logic rtc_osc,
	output logic ext_osc,
	output logic usb_osc,
	output var int cnt [PN+6],
	output var int min_high
);
	localparam int HALF [3] = '{RTC_HALF, EXT_HALF, USB_HALF};
	logic [2:0] osc = 3'b000;
	int ph [3];
	logic [PN+5:0] prev = '0;
	logic [PN+5:0] all_in;
	int run = 0;
	logic seen = 1'b0;

	assign rtc_osc = osc[0];
	assign ext_osc = osc[1];
	assign usb_osc = osc[2];
	assign all_in = {osc[1:0], taps};

	always_ff @(posedge aclk) begin
		for (int i = 0; i < 3; i++) begin
			ph[i] <= (ph[i] >= HALF[i] - 1) ? 0 : ph[i] + 1;
			if (ph[i] >= HALF[i] - 1)
				osc[i] <= !osc[i];
		end
	end

	always_ff @(posedge aclk) begin
		prev <= all_in;
		for (int i = 0; i < PN + 6; i++) begin
			if (clear)
				cnt[i] <= 0;
			else if (all_in[i] && !prev[i])
				cnt[i] <= cnt[i] + 1;
		end
	end

	// Shortest core clock high phase; a runt shows as a small value
	always_ff @(posedge aclk) begin
		if (clear) begin
			seen <= 1'b0;
			min_high <= 1000;
		end else if (taps[0] && !prev[0]) begin
			seen <= 1'b1;
			run <= 1;
		end else if (taps[0]) begin
			run <= run + 1;
		end else if (prev[0] && seen && run < min_high) begin
			min_high <= run;
		end
	end
endmodule // clock_consumer_model

`default_nettype wire

// ===== tb/clock_select_checker.sv
// Assertions for the clock select block.
// Assumes binding into system_clock_select; sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module clock_select_checker #(
	parameter int PERIPH_COUNT = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic ref_source_strap,
	input wire logic rtc_wake_request,
	input wire logic core_system_clock,
	input wire logic cpu_domain_clock,
	input wire logic [PERIPH_COUNT-1:0] periph_clock,
	input wire logic usb_osc_enable,
	input wire logic usb_pll_enable,
	input wire logic rtc_regs_accessible,
	input wire logic rtc_wakeup_event
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	cpu_clk_same_a: assert property (cpu_domain_clock == core_system_clock)
		else $error("cpu clock off core");
	periph_in_core_a: assert property ((periph_clock & ~{PERIPH_COUNT{core_system_clock}}) == '0)
		else $error("gate high, core low");
	gate_rise_clean_a: assert property (|(periph_clock & ~$past(periph_clock)) |-> $rose(core_system_clock))
		else $error("gate rise off core rise");
	gate_fall_clean_a: assert property (|($past(periph_clock) & ~periph_clock) |-> $fell(core_system_clock))
		else $error("gate fall off core fall");
	rtc_access_a: assert property ($stable(ref_source_strap) [*8] |-> rtc_regs_accessible == !ref_source_strap)
		else $error("rtc access off strap");
	usb_pll_osc_a: assert property (usb_pll_enable |-> usb_osc_enable)
		else $error("usb pll without osc");
	wake_follows_a: assert property ($rose(rtc_wake_request) |-> ##[1:10] rtc_wakeup_event)
		else $error("no wake event");
	wake_single_a: assert property (rtc_wakeup_event |=> !rtc_wakeup_event)
		else $error("wake event too long");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
endmodule // clock_select_checker

bind system_clock_select clock_select_checker #(.PERIPH_COUNT(PERIPH_COUNT)) checker_i (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.ref_source_strap(ref_source_strap),
	.rtc_wake_request(rtc_wake_request),
	.core_system_clock(core_system_clock),
	.cpu_domain_clock(cpu_domain_clock),
	.periph_clock(periph_clock),
	.usb_osc_enable(usb_osc_enable),
	.usb_pll_enable(usb_pll_enable),
	.rtc_regs_accessible(rtc_regs_accessible),
	.rtc_wakeup_event(rtc_wakeup_event)
);

`default_nettype wire

// ===== tb/system_clock_select_and_domains_tb.sv
// Self-checking bench for the clock select block.
// Assumes the consumer model supplies oscillators and edge counts.
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_cfg.svh"

module system_clock_select_and_domains_tb;
	localparam int PN = 8;
	localparam int CORE = 0;
	localparam int CPU = 1;
	localparam int USB = 2;
	localparam int WAKE = 3;
	localparam int P0 = 4;
	localparam int RTC = PN + 4;
	localparam int EXT = PN + 5;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [`CS_ADDR_W-1:0] s_axi_awaddr = '0;
	logic [`CS_ADDR_W-1:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic strap = 1'b0;
	logic wake = 1'b0;
	logic clear = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic core, cpu, usb_ref, usb_osc_en, usb_pll_en, rtc_acc, wake_ev, dbg_oe;
	logic rtc, ext, usbosc;
	logic [PN-1:0] periph;
	int cnt [PN+6];
	int min_high;
	int bad_count = 0;
	int total_checks = 0;
	logic [31:0] d;
	logic [1:0] r;

	system_clock_select #(.PERIPH_COUNT(PN)) uut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'b000), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'b1111),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'b000), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .rtc_osc_clock(rtc), .ext_ref_clock_pin(ext),
		.ref_source_strap(strap), .usb_osc_clock(usbosc), .rtc_wake_request(wake),
		.core_system_clock(core), .cpu_domain_clock(cpu), .periph_clock(periph),
		.pll_reference_input(), .usb_ref_clock(usb_ref), .usb_osc_enable(usb_osc_en),
		.usb_pll_enable(usb_pll_en), .rtc_regs_accessible(rtc_acc), .rtc_wakeup_event(wake_ev),
		.debug_clock_output(), .debug_clock_output_oe(dbg_oe)
	);

	clock_consumer_model #(.PN(PN)) far_side (
		.aclk(aclk), .clear(clear), .taps({periph, wake_ev, usb_ref, cpu, core}),
		.rtc_osc(rtc), .ext_osc(ext), .usb_osc(usbosc), .cnt(cnt), .min_high(min_high)
	);

	initial begin
		forever #5 aclk = ~aclk;
	end

	task automatic print_verdict();
		if (bad_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Tolerance allows a partial period at each end of a window
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got,
		input int tol = 0);
		total_checks++;
		if (^got === 1'bx || got + tol < exp || got > exp + tol) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_done = 0, w_done = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic win(input int n);
		@(posedge aclk);
		clear <= 1'b1;
		@(posedge aclk);
		clear <= 1'b0;
		repeat (n) @(posedge aclk);
	endtask

	task automatic t_reset();
		logic [7:0] a [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18};
		logic [31:0] e [6] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_0000,
			32'h0000_00FF, 32'h0000_0000, 32'h0000_0001};
		chk("debug oe at reset", 32'h0000_0000, 32'(dbg_oe));
		foreach (a[i]) begin
			axi_read(a[i], d, r);
			chk("reset value", e[i], d);
		end
		axi_read(8'h20, d, r);
		chk("unmapped read resp", 32'(`CS_RESP_SLVERR), 32'(r));
		chk("unmapped read data", 32'h0000_0000, d);
		axi_write(8'h24, 32'h0000_FFFF, r);
		chk("unmapped write resp", 32'(`CS_RESP_SLVERR), 32'(r));
	endtask

	task automatic t_bypass();
		win(800);
		chk("core vs rtc", cnt[RTC], cnt[CORE], 2);
		chk("cpu edges", cnt[CORE], cnt[CPU], 2);
		chk("rtc access", 32'h0000_0001, 32'(rtc_acc));
		strap <= 1'b1;
		repeat (40) @(posedge aclk);
		win(800);
		chk("core vs ext", cnt[EXT], cnt[CORE], 2);
		chk("rtc access ext", 32'h0000_0000, 32'(rtc_acc));
		axi_read(`CS_OFF_CLOCK_STATUS, d, r);
		chk("status strap", 32'h0000_0001, d & 32'h0000_0001);
		strap <= 1'b0;
		repeat (60) @(posedge aclk);
	endtask

	task automatic t_periph();
		axi_write(`CS_OFF_PERIPH_GATE, 32'h0000_0005, r);
		repeat (100) @(posedge aclk);
		win(800);
		chk("periph 0", cnt[CORE], cnt[P0], 2);
		chk("periph 1 off", 32'h0000_0000, cnt[P0+1]);
		chk("periph 2", cnt[CORE], cnt[P0+2], 2);
		axi_write(`CS_OFF_PERIPH_GATE, 32'h0000_00FF, r);
	endtask

	task automatic t_pll();
		int n = 0;
		axi_write(`CS_OFF_PLL_RATIO, 32'h0000_0004, r);
		axi_write(`CS_OFF_GEN_CONTROL_ONE, 32'h0000_0000, r);
		d = '0;
		while (d[`CS_BIT_LOCK] !== 1'b1 && n < 400) begin
			axi_read(`CS_OFF_GEN_CONTROL_THREE, d, r);
			n++;
		end
		chk("pll lock", 32'h0000_0008, d & 32'h0000_0008);
		axi_write(`CS_OFF_CLOCK_CONFIG_TWO, 32'h0000_0001, r);
		win(300);
		chk("no runt", 32'h0000_0001, 32'(min_high >= 8));
		win(800);
		chk("pll x2", 2 * cnt[RTC], cnt[CORE], 2);
		axi_read(`CS_OFF_CLOCK_STATUS, d, r);
		chk("pll path", 32'h0000_0002, d & 32'h0000_0002);
		axi_write(`CS_OFF_GEN_CONTROL_ONE, 32'h0000_0001, r);
		win(100);
		win(800);
		chk("powerdown bypass", cnt[RTC], cnt[CORE], 2);
		axi_write(`CS_OFF_CLOCK_CONFIG_TWO, 32'h0000_0000, r);
		axi_write(`CS_OFF_GEN_CONTROL_ONE, 32'h0000_0002, r);
	endtask

	task automatic t_usb();
		axi_write(`CS_OFF_USB_CONTROL, 32'h0000_0003, r);
		repeat (10) @(posedge aclk);
		chk("usb enables", 32'h0000_0003, {30'h0, usb_pll_en, usb_osc_en});
		win(200);
		chk("usb ref runs", 32'h0000_0001, 32'(cnt[USB] > 10));
		axi_write(`CS_OFF_USB_CONTROL, 32'h0000_0002, r);
		repeat (10) @(posedge aclk);
		chk("usb disabled", 32'h0000_0000, {30'h0, usb_pll_en, usb_osc_en});
		win(200);
		chk("usb ref stopped", 32'h0000_0000, cnt[USB]);
	endtask

	task automatic t_debug_wake();
		axi_write(`CS_OFF_CPU_STATUS_THREE, 32'h0000_0000, r);
		repeat (4) @(posedge aclk);
		chk("debug oe on", 32'h0000_0001, 32'(dbg_oe));
		axi_write(`CS_OFF_CPU_STATUS_THREE, 32'h0000_0001, r);
		repeat (4) @(posedge aclk);
		chk("debug oe off", 32'h0000_0000, 32'(dbg_oe));
		wake <= 1'b1;
		win(60);
		wake <= 1'b0;
		repeat (20) @(posedge aclk);
		chk("wake events", 32'h0000_0001, cnt[WAKE]);
	endtask

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset();
		t_bypass();
		t_periph();
		t_pll();
		t_usb();
		t_debug_wake();
		print_verdict();
	end

	initial begin
		repeat (40000) @(posedge aclk);
		bad_count++;
		print_verdict();
	end
endmodule // system_clock_select_and_domains_tb

`default_nettype wire
